// >>> pxe_pkg.sv
// package for the two-wire port expander link: states, fixed address, reset values
// assumes both ends import it whole
`default_nettype none
package pxe_pkg;
  // ------------------------------------------------------------
  // address and widths
  // ------------------------------------------------------------
  localparam logic [3:0] PXE_ADDR_FIXED = 4'h4;   // arbitrary upper address bits
  localparam logic [6:0] PXE_GENERAL_CALL = 7'h00;
  localparam int PXE_BYTE_BITS = 8;
  localparam logic [3:0] PXE_BIT_LAST = 4'h7;
  localparam logic [3:0] PXE_BIT_ACK = 4'h8;
  localparam logic [15:0] PXE_PORT_RESET = 16'hffff;
  // ------------------------------------------------------------
  // timing of the host's divider
  // ------------------------------------------------------------
  localparam int PXE_CLK_NS = 4;
  localparam int PXE_SCL_HALF_NS = 1250;
  localparam int PXE_SCL_HALF_CYC = (PXE_SCL_HALF_NS + PXE_CLK_NS - 1) / PXE_CLK_NS;
  localparam logic [8:0] PXE_HALF_LAST = 9'(PXE_SCL_HALF_CYC - 1);
  // ------------------------------------------------------------
  // link states
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    PXE_S_IDLE = 5'b00001,
    PXE_S_ADDR = 5'b00010,
    PXE_S_WRITE = 5'b00100,
    PXE_S_READ = 5'b01000,
    PXE_S_IGNORE = 5'b10000
  } pxe_dev_state_t;
  typedef enum logic [5:0] {
    PXE_H_IDLE = 6'b000001,
    PXE_H_START = 6'b000010,
    PXE_H_BIT = 6'b000100,
    PXE_H_ACK = 6'b001000,
    PXE_H_STOP = 6'b010000,
    PXE_H_DONE = 6'b100000
  } pxe_host_state_t;
endpackage : pxe_pkg
`default_nettype wire

// >>> pxe_if.sv
// two-wire link between expander device and its host; resolves open-drain levels
// assumes pull-ups: a line is low only while some party enables its driver
`default_nettype none
interface pxe_if;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_host;
  assign sda = ~(sda_oe_host | sda_oe_dev);
  modport device (input scl, input sda, output sda_oe_dev);
  modport host (input scl, input sda, output scl_oe_host, output sda_oe_host);
endinterface : pxe_if
`default_nettype wire

// >>> pxe_sync.sv
// three-stage synchroniser with agreement on the last two stages
// assumes the input is asynchronous to clk
`default_nettype none
module pxe_sync
  import pxe_pkg::*;
#(
  parameter logic INIT = 1'b1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      dout <= INIT;
    else if (s2 == s3)
      dout <= s3;
  end
endmodule : pxe_sync
`default_nettype wire

// >>> pxe_device.sv
// target end of the expander: address match, 16-bit port latch, read of port pins,
// interrupt on input change
// assumes scl_clk is the bus clock line itself; sda changes only while scl is low,
// except for start and stop
//
// Behaviour
// [RULE1] master starts only on idle bus
// [RULE2] sda fall with scl high restarts address
// [RULE3] address msb first, direction bit last
// [RULE4] general call is never acknowledged
// [RULE5] own address acknowledged on ninth clock
// [RULE6] address select pins steady start to stop
// [RULE7] read sends port pins, write drives port
// [RULE8] every accepted write byte is acknowledged
// [RULE9] extra bytes: conflicting, pairs taken instead
// [RULE10] port changes only after complete acknowledged pair
// [RULE11] port updates at ack clock rising edge
// [RULE12] one bit per clock, sda stable high
// [RULE13] sda rise with scl high ends transfer
// [RULE14] unlimited bytes, ack slot after each
// [RULE15] transmitter releases sda before ack slot
// [RULE16] master acks read bytes except last
// [RULE17] acknowledger holds sda low whole high
// [RULE18] master nack ends read, device releases
// [RULE19] device never limits byte count
// [RULE20] byte pairs: low port then high
// [RULE21] input edge raises interrupt
// [RULE22] interrupt clears at ack or restore
// [RULE23] reset: idle link, port lines high
// [RULE24] address: fixed upper, select pins lower
`default_nettype none
module pxe_device
  import pxe_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  pxe_if.device link,
  input wire logic scl_clk,
  input wire logic [2:0] addr_select_pins,
  input wire logic [7:0] low_port_in,
  input wire logic [7:0] high_port_in,
  output logic [7:0] low_port_lines,
  output logic [7:0] high_port_lines,
  output logic int_oe
);
  // ------------------------------------------------------------
  // start / stop detection
  // ------------------------------------------------------------
  // start and stop are sda edges while scl is high; sda itself is their clock.
  // toggles cross into the scl domain so no signal has two clock domains.
  logic start_tgl;
  logic stop_tgl;
  always_ff @(negedge link.sda or posedge reset)
  begin
    if (reset)
      start_tgl <= 1'b0;
    else if (link.scl)
      start_tgl <= ~start_tgl; // see [RULE2]
  end
  always_ff @(posedge link.sda or posedge reset)
  begin
    if (reset)
      stop_tgl <= 1'b0;
    else if (link.scl)
      stop_tgl <= ~stop_tgl; // see [RULE13]
  end

  // a start or stop seen since the last scl edge is taken at the next rising edge
  logic start_seen;
  logic stop_seen;
  logic start_ack;
  logic stop_ack;
  assign start_seen = start_tgl != start_ack;
  assign stop_seen = stop_tgl != stop_ack;

  // ------------------------------------------------------------
  // bit shifting on scl
  // ------------------------------------------------------------
  pxe_dev_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic rw;
  logic pair_hi;
  logic [7:0] low_hold;
  logic ack_drive;
  logic tx_drive;
  logic [7:0] tx_byte;
  logic [15:0] port_q;
  logic ack_tgl;
  logic [6:0] own_addr;
  assign own_addr = {PXE_ADDR_FIXED, addr_select_pins}; // see [RULE24] [RULE6]

  always_ff @(posedge scl_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= PXE_S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      pair_hi <= 1'b0;
      low_hold <= 8'hff;
      port_q <= PXE_PORT_RESET; // see [RULE23]
      start_ack <= 1'b0;
      stop_ack <= 1'b0;
      ack_tgl <= 1'b0;
    end
    else
    begin
      start_ack <= start_tgl;
      stop_ack <= stop_tgl;
      if (start_seen)
      begin
        // a cut partial byte is dropped; port untouched
        state <= PXE_S_ADDR; // see [RULE2] [RULE10]
        bit_cnt <= 4'h1;
        shreg <= {7'h00, link.sda};
        pair_hi <= 1'b0;
      end
      else if (stop_seen)
        state <= PXE_S_IDLE; // see [RULE13] [RULE1]
      else
      begin
        case (state)
          PXE_S_IDLE: state <= PXE_S_IDLE;
          PXE_S_IGNORE: state <= PXE_S_IGNORE; // see [RULE4]
          default:
          begin
            if (bit_cnt == PXE_BIT_ACK)
            begin
              bit_cnt <= 4'h0;
              if (state == PXE_S_ADDR)
              begin
                if (shreg[7:1] == own_addr && shreg[7:1] != PXE_GENERAL_CALL)
                begin
                  rw <= shreg[0];
                  state <= shreg[0] ? PXE_S_READ : PXE_S_WRITE; // see [RULE7]
                end
                else
                  state <= PXE_S_IGNORE; // see [RULE4]
              end
              else if (state == PXE_S_WRITE)
              begin
                // ack clock: byte is complete and acknowledged
                pair_hi <= ~pair_hi; // see [RULE20] [RULE9]
                ack_tgl <= ~ack_tgl; // see [RULE22]
                if (!pair_hi)
                  low_hold <= shreg;
                else
                  port_q <= {shreg, low_hold}; // see [RULE10] [RULE11]
              end
              else
              begin
                pair_hi <= ~pair_hi;
                if (link.sda)
                  state <= PXE_S_IGNORE; // see [RULE18] [RULE16]
              end
            end
            else
            begin
              shreg <= {shreg[6:0], link.sda}; // see [RULE3] [RULE12]
              bit_cnt <= bit_cnt + 4'h1; // see [RULE14] [RULE19]
            end
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // sda drive on falling scl
  // ------------------------------------------------------------
  logic [15:0] pins;
  assign pins = {high_port_in, low_port_in};
  always_ff @(negedge scl_clk or posedge reset)
  begin
    if (reset)
    begin
      ack_drive <= 1'b0;
      tx_drive <= 1'b0;
      tx_byte <= 8'h00;
    end
    else
    begin
      ack_drive <= 1'b0; // see [RULE15]
      tx_drive <= 1'b0;
      if (bit_cnt == PXE_BIT_ACK && !start_seen)
      begin
        // ninth clock: ack own address and each written byte
        if (state == PXE_S_ADDR)
          ack_drive <= shreg[7:1] == own_addr && shreg[7:1] != PXE_GENERAL_CALL; // see [RULE5]
        else if (state == PXE_S_WRITE)
          ack_drive <= 1'b1; // see [RULE8] [RULE17]
      end
      else if (state == PXE_S_READ && bit_cnt == 4'h0)
      begin
        // load next byte of pins at start of byte
        tx_byte <= pair_hi ? pins[15:8] : pins[7:0]; // see [RULE7] [RULE20]
        tx_drive <= pair_hi ? ~pins[15] : ~pins[7];
      end
      else if (state == PXE_S_READ && bit_cnt < PXE_BIT_ACK)
        tx_drive <= ~tx_byte[3'(PXE_BIT_LAST - bit_cnt)]; // see [RULE3]
    end
  end
  assign link.sda_oe_dev = ack_drive | tx_drive;

  // ------------------------------------------------------------
  // port outputs and interrupt, in clk domain
  // ------------------------------------------------------------
  logic [15:0] pin_sync;
  logic ack_sync;
  logic ack_seen;
  logic [15:0] pin_ref;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_sync
      pxe_sync #(.INIT(1'b1)) u_pin (.clk(clk), .reset(reset), .din(pins[gi]),
        .dout(pin_sync[gi]));
    end
  endgenerate
  pxe_sync #(.INIT(1'b0)) u_ack (.clk(clk), .reset(reset), .din(ack_tgl), .dout(ack_sync));

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      low_port_lines <= PXE_PORT_RESET[7:0]; // see [RULE23]
      high_port_lines <= PXE_PORT_RESET[15:8];
    end
    else if (ack_sync != ack_seen)
    begin
      // the ack toggle is the handshake: port_q settled well before it arrives
      low_port_lines <= port_q[7:0]; // see [RULE11]
      high_port_lines <= port_q[15:8];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_seen <= 1'b0;
      pin_ref <= PXE_PORT_RESET;
      int_oe <= 1'b0;
    end
    else
    begin
      ack_seen <= ack_sync;
      // a written-byte ack re-arms: current pins become the reference
      if (ack_sync != ack_seen)
      begin
        pin_ref <= pin_sync;
        int_oe <= 1'b0; // see [RULE22]
      end
      else
        int_oe <= pin_sync != pin_ref; // see [RULE21] [RULE22]
    end
  end
endmodule : pxe_device
`default_nettype wire

// >>> pxe_host.sv
// master end: makes scl by dividing clk, writes a port pair or reads a pair of bytes
// assumes one request at a time; a single device answers at req_addr
`default_nettype none
module pxe_host
  import pxe_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  pxe_if.host link,
  input wire logic req,
  input wire logic req_read,
  input wire logic [6:0] req_addr,
  input wire logic [15:0] req_data,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [15:0] rd_data
);
  pxe_host_state_t state;
  logic [8:0] div;
  logic phase;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] txb;
  logic [7:0] rxb;
  logic sda_in;
  logic tick;
  logic sda_late;
  logic sda_next;
  logic [7:0] next_txb;
  pxe_sync #(.INIT(1'b1)) u_sda (.clk(clk), .reset(reset), .din(link.sda), .dout(sda_in));
  assign tick = div == PXE_HALF_LAST;

  function automatic logic [7:0] pick(input logic [1:0] idx, input logic [7:0] a,
      input logic [15:0] d);
    pick = idx == 2'h0 ? a : (idx == 2'h1 ? d[7:0] : d[15:8]);
  endfunction : pick
  assign next_txb = pick(byte_idx + 2'h1, txb, req_data);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      div <= 9'h000;
    else
      div <= tick || state == PXE_H_IDLE ? 9'h000 : div + 9'h001;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= PXE_H_IDLE;
      phase <= 1'b0;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      txb <= 8'h00;
      rxb <= 8'h00;
      link.scl_oe_host <= 1'b0;
      link.sda_oe_host <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      rd_data <= 16'h0000;
      sda_late <= 1'b0;
      sda_next <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      // sda moves one clk after scl falls: an sda edge never meets an scl edge
      sda_late <= 1'b0;
      if (sda_late)
        link.sda_oe_host <= sda_next; // see [RULE12]
      case (state)
        PXE_H_IDLE:
        begin
          if (req && sda_in) // see [RULE1]
          begin
            busy <= 1'b1;
            nack <= 1'b0;
            txb <= {req_addr, req_read}; // see [RULE3]
            byte_idx <= 2'h0;
            link.sda_oe_host <= 1'b1; // see [RULE2]
            state <= PXE_H_START;
          end
        end
        PXE_H_START:
          if (tick)
          begin
            link.scl_oe_host <= 1'b1;
            sda_next <= ~txb[7];
            sda_late <= 1'b1;
            bit_cnt <= 4'h0;
            phase <= 1'b0;
            state <= PXE_H_BIT;
          end
        PXE_H_BIT:
          if (tick)
          begin
            phase <= ~phase;
            link.scl_oe_host <= phase; // see [RULE12]
            if (!phase)
              rxb <= {rxb[6:0], sda_in};
            else if (bit_cnt == PXE_BIT_LAST)
            begin
              // release sda so the receiver can ack, or drive our own ack
              sda_next <= req_read && byte_idx == 2'h1; // see [RULE15] [RULE16] [RULE18]
              sda_late <= 1'b1;
              state <= PXE_H_ACK;
            end
            else
            begin
              bit_cnt <= bit_cnt + 4'h1;
              sda_late <= 1'b1;
              sda_next <= byte_idx != 2'h0 && req_read ? 1'b0
                : ~txb[3'(PXE_BIT_LAST - bit_cnt - 4'h1)];
            end
          end
        PXE_H_ACK:
          if (tick)
          begin
            phase <= ~phase;
            link.scl_oe_host <= phase;
            if (!phase)
            begin
              if (byte_idx == 2'h1)
                rd_data[7:0] <= rxb; // see [RULE20]
              if (byte_idx == 2'h2)
                rd_data[15:8] <= rxb;
              if ((byte_idx == 2'h0 || !req_read) && sda_in)
                nack <= 1'b1; // see [RULE5] [RULE8]
            end
            else
            begin
              bit_cnt <= 4'h0;
              if (byte_idx == 2'h2 || nack)
              begin
                sda_next <= 1'b1;
                sda_late <= 1'b1;
                state <= PXE_H_STOP;
              end
              else
              begin
                byte_idx <= byte_idx + 2'h1;
                txb <= next_txb;
                sda_next <= req_read ? 1'b0 : ~next_txb[7];
                sda_late <= 1'b1;
                state <= PXE_H_BIT;
              end
            end
          end
        PXE_H_STOP:
          if (tick)
          begin
            phase <= ~phase;
            if (!phase)
              link.scl_oe_host <= 1'b0;
            else
            begin
              link.sda_oe_host <= 1'b0; // see [RULE13]
              state <= PXE_H_DONE;
            end
          end
        PXE_H_DONE:
          if (tick)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= PXE_H_IDLE;
          end
        default: state <= PXE_H_IDLE;
      endcase
    end
  end
endmodule : pxe_host
`default_nettype wire

// >>> pxe_link_checker.sv
// link checker: framing, acknowledge and release on the shared two-wire lines
// assumes scl and sda are the resolved levels and clk is the host's clock
`default_nettype none
module pxe_link_checker
  import pxe_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_oe_host,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic scl,
  input wire logic sda,
  input wire logic [2:0] addr_select_pins
);
  // ------------------------------------------------------------
  // bus decoding
  // ------------------------------------------------------------
  logic scl_q, sda_q, in_frame, byte0, own, rw, ign;
  logic [3:0] slot;
  logic [7:0] shreg;
  logic start_ev, stop_ev, fall, ack_hi, match;
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev = scl & scl_q & ~sda_q & sda;
  assign fall = scl_q & ~scl;
  assign ack_hi = in_frame & scl & (slot == 4'h8);
  assign match = shreg[7:1] == {PXE_ADDR_FIXED, addr_select_pins};
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      shreg <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && !scl_q && slot < 4'h8)
        shreg <= {shreg[6:0], sda};
    end
  end
  // slot f spans the gap between start and the first fall of scl
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      slot <= 4'hf;
      byte0 <= 1'b1;
      in_frame <= 1'b0;
      own <= 1'b0;
      ign <= 1'b0;
      rw <= 1'b0;
    end
    else if (start_ev || stop_ev)
    begin
      slot <= 4'hf;
      byte0 <= 1'b1;
      in_frame <= start_ev;
      own <= 1'b0;
      ign <= 1'b0;
    end
    else if (fall)
    begin
      slot <= (slot == 4'h8 || slot == 4'hf) ? 4'h0 : slot + 4'h1;
      if (slot == 4'h8)
        byte0 <= 1'b0;
      if (slot == 4'h8 && byte0)
      begin
        own <= match;
        ign <= !match;
        rw <= shreg[0];
      end
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  addr_ack_held_a: assert property (ack_hi && byte0 && match
    |-> !sda)
    else $error("own address not acknowledged in the ninth clock");
  foreign_quiet_a: assert property (in_frame
    && (ign || (byte0 && slot == 4'h8 && !match)) |-> !sda_oe_dev)
    else $error("device drove sda for a foreign address");
  write_ack_a: assert property (ack_hi && !byte0 && own && !rw
    |-> !sda)
    else $error("written byte not acknowledged");
  read_release_a: assert property (ack_hi && !byte0 && own && rw
    |-> !sda_oe_dev)
    else $error("device held sda in the host acknowledge slot");
  high_stable_a: assert property (scl && $past(scl)
    |-> $stable(sda_oe_dev))
    else $error("device moved sda while scl high");
  no_clash_a: assert property (scl && sda_oe_dev |-> !sda_oe_host)
    else $error("both ends drive sda in a high phase");
  idle_quiet_a: assert property (!in_frame |-> !sda_oe_dev)
    else $error("device drove sda outside a frame");
  start_clock_a: assert property (start_ev |-> ##[1:700] !scl)
    else $error("no clock after start");
endmodule : pxe_link_checker
`default_nettype wire

// >>> tb_i2c_slave_port_expander.sv
// bench: host and device joined by the link; user sides and pins driven here
// assumes package timing; scl is made by the host divider
`default_nettype none
module tb_i2c_slave_port_expander
  import pxe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, req, req_read, busy, done, nack, int_oe;
  logic [6:0] req_addr;
  logic [15:0] req_data, rd_data, d;
  logic [2:0] addr_select_pins;
  logic [7:0] low_port_in, high_port_in, low_port_lines, high_port_lines;
  int err_count, n_tests;
  pxe_if link();
  pxe_host u_pxe_host(.clk(clk), .reset(reset), .link(link), .req(req), .req_read(req_read),
    .req_addr(req_addr), .req_data(req_data), .busy(busy), .done(done), .nack(nack),
    .rd_data(rd_data));
  pxe_device u_pxe_device(.clk(clk), .reset(reset), .link(link), .scl_clk(link.scl),
    .addr_select_pins(addr_select_pins), .low_port_in(low_port_in),
    .high_port_in(high_port_in), .low_port_lines(low_port_lines),
    .high_port_lines(high_port_lines), .int_oe(int_oe));
  pxe_link_checker u_pxe_link_checker(.clk(clk), .reset(reset),
    .scl_oe_host(link.scl_oe_host), .sda_oe_host(link.sda_oe_host),
    .sda_oe_dev(link.sda_oe_dev), .scl(link.scl), .sda(link.sda),
    .addr_select_pins(addr_select_pins));
  // ------------------------------------------------------------
  // expectations and helpers
  // ------------------------------------------------------------
  function automatic logic [6:0] own_addr(input logic [2:0] sel);
    return {PXE_ADDR_FIXED, sel};
  endfunction : own_addr
  function automatic logic [15:0] port_word(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo};
  endfunction : port_word
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic pulse_reset();
    reset = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
  endtask : pulse_reset
  // one whole pair per request; req held until the host shows busy
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd);
    int i;
    @(posedge clk);
    #1;
    req = 1'b1;
    req_read = rd;
    req_addr = a;
    req_data = wd;
    for (i = 0; i < 100 && busy !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    req = 1'b0;
    for (i = i; i < 30000 && done !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i >= 30000)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask : xfer
  // pins pass a synchroniser, so the flag follows a few cycles late
  task automatic wait_int(input logic v);
    int i;
    for (i = 0; i < 100 && int_oe !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    check({15'h0000, int_oe}, {15'h0000, v});
  endtask : wait_int
  // ------------------------------------------------------------
  // clock and sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    reset = 1'b1;
    req = 1'b0;
    req_read = 1'b0;
    req_addr = 7'h00;
    req_data = 16'h0000;
    low_port_in = 8'h00;
    high_port_in = 8'h00;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'he00e56df));
    addr_select_pins = 3'($urandom);
    pulse_reset();
    check(port_word(low_port_lines, high_port_lines), PXE_PORT_RESET);
    check({15'h0000, int_oe}, 16'h0000);
    d = 16'($urandom);
    xfer(1'b0, own_addr(addr_select_pins), d);
    check({15'h0000, nack}, 16'h0000);
    check({15'h0000, busy}, 16'h0000);
    check(port_word(low_port_lines, high_port_lines), d);
    // neighbour address and general call are refused, port untouched
    xfer(1'b0, own_addr(addr_select_pins ^ 3'h1), ~d);
    check({15'h0000, nack}, 16'h0001);
    check(port_word(low_port_lines, high_port_lines), d);
    xfer(1'b0, PXE_GENERAL_CALL, ~d);
    check({15'h0000, nack}, 16'h0001);
    check(port_word(low_port_lines, high_port_lines), d);
    low_port_in = 8'($urandom);
    high_port_in = 8'($urandom);
    xfer(1'b1, own_addr(addr_select_pins), 16'h0000);
    check(rd_data, port_word(low_port_in, high_port_in));
    check({15'h0000, nack}, 16'h0000);
    // all-zero pair captures the pin reference, then one pin toggles
    low_port_in = 8'h5a;
    high_port_in = 8'ha5;
    xfer(1'b0, own_addr(addr_select_pins), 16'h0000);
    check(port_word(low_port_lines, high_port_lines), 16'h0000);
    wait_int(1'b0);
    low_port_in = 8'h5b;
    wait_int(1'b1);
    low_port_in = 8'h5a;
    wait_int(1'b0);
    pulse_reset();
    check(port_word(low_port_lines, high_port_lines), PXE_PORT_RESET);
    tally_and_finish();
  end
endmodule : tb_i2c_slave_port_expander
`default_nettype wire
